// File: src/event_counter_consts.svh
// Constants for the multi-mode event counter: limits, clock rate and filter settings.
`ifndef EVENT_COUNTER_CONSTS_SVH
`define EVENT_COUNTER_CONSTS_SVH

// System clock rate in Hz (20 ns period).
`define SYS_CLK_HZ 50000000
// Hz per kHz, doubled because a filter must pass a high or low phase of half a period.
`define FILT_HZ_PER_KHZ_X2 2000
// Widest filter count the filter counters can hold.
`define FILT_CNT_MAX 65535

// Signed count limits of the full range, reset value and unit step.
`define CNT_UPPER_LIMIT 32'sh7FFFFFFF
`define CNT_LOWER_LIMIT 32'sh80000000
`define CNT_RESET 32'sh00000000
`define CNT_ONE 32'sh00000001

// Maximum-frequency selector codes and the kHz figure each stands for.
`define FSEL_1K 3'h0
`define FSEL_2K 3'h1
`define FSEL_5K 3'h2
`define FSEL_10K 3'h3
`define FSEL_30K 3'h4
`define FSEL_60K 3'h5
`define KHZ_1 1
`define KHZ_2 2
`define KHZ_5 5
`define KHZ_10 10
`define KHZ_30 30
`define KHZ_60 60

// Interrupt cause bit positions.
`define IRQ_GATE_OPEN 0
`define IRQ_GATE_CLOSE 1
`define IRQ_CMP 2
`define IRQ_OVF 3
`define IRQ_UNF 4
`define IRQ_W 5

// Pin index within the filtered input bundle.
`define PIN_A 0
`define PIN_B 1
`define PIN_GATE 2
`define PIN_LATCH 3
`define PIN_N 4

`endif

// File: src/event_counter_pkg.sv
// Types shared by the multi-mode event counter and its bench.
`default_nettype none
package event_counter_pkg;
	typedef logic signed [31:0] count_t;
	typedef enum logic [2:0] {MODE_CONT = 3'b001, MODE_ONCE = 3'b010, MODE_PERIODIC = 3'b100} op_mode_t;
	typedef enum logic [2:0] {DIR_NONE = 3'b001, DIR_FWD = 3'b010, DIR_BWD = 3'b100} main_dir_t;
	typedef enum logic [3:0] {
		EVAL_PULSE_DIR = 4'b0001,
		EVAL_X1 = 4'b0010,
		EVAL_X2 = 4'b0100,
		EVAL_X4 = 4'b1000
	} sig_eval_t;
	typedef enum logic [3:0] {
		CMP_NONE = 4'b0001,
		CMP_GE = 4'b0010,
		CMP_LE = 4'b0100,
		CMP_EQ = 4'b1000
	} cmp_mode_t;
endpackage : event_counter_pkg
`default_nettype wire

// File: src/multi_mode_event_counter.sv
// Multi-mode 32-bit signed event counter with filtered pins, gate control and interrupt events.
//
// Operation
// - Gate-opening interrupt on hardware gate rising edge while software gate open.
// - Gate-closing interrupt on hardware gate falling edge while software gate open.
// - Comparator interrupt on each comparator trigger when enabled.
// - Overflow interrupt when counting beyond the upper limit, if enabled.
// - Underflow interrupt when counting below the lower limit, if enabled.
// - Count and gate pin filters selectable 1 to 60 kHz, default 60.
// - Latch pin filter selectable separately, default 60 kHz.
// - Continuous mode wraps upper limit to lower limit on forward pulse.
// - Continuous mode wraps lower limit to upper limit on backward pulse.
// - Overflow and underflow flags stay set until status clear request.
// - Count once, no direction: wrap to opposite limit and close gate.
// - Auto-closed gate reopens on gate rising edge; abort reloads, interrupt continues.
// - Count once forward: pulse after end minus one reloads and closes gate.
// - Count once backward: pulse after end plus one reloads and closes gate.
// - Periodic, no direction: reload at full-range limits and keep counting.
// - Periodic forward: reload after end minus one, keep counting.
// - Periodic backward: reload after end plus one, keep counting.
// - Hardware gate disabled: software gate alone controls counting.
`include "event_counter_consts.svh"
`default_nettype none
module multi_mode_event_counter #(
	parameter int unsigned FILT_CLK_HZ = `SYS_CLK_HZ
) (
	// Clock, reset and clock enable.
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clkEn,
	// Pins from the pulse source.
	input wire logic trackAPin,
	input wire logic trackBPin,
	input wire logic hardwareGatePin,
	input wire logic latchPin,
	// Configuration.
	input wire event_counter_pkg::op_mode_t opMode,
	input wire event_counter_pkg::main_dir_t mainDir,
	input wire event_counter_pkg::sig_eval_t signalEval,
	input wire event_counter_pkg::cmp_mode_t cmpMode,
	input wire logic dirInvert,
	input wire logic hwGateEnable,
	input wire logic gateAbort,
	input wire logic [2:0] countFreqSel,
	input wire logic [2:0] latchFreqSel,
	input wire event_counter_pkg::count_t loadValue,
	input wire event_counter_pkg::count_t endValue,
	input wire event_counter_pkg::count_t cmpValue,
	// Interrupt enables.
	input wire logic irqEnGateOpen,
	input wire logic irqEnGateClose,
	input wire logic irqEnCmp,
	input wire logic irqEnOvf,
	input wire logic irqEnUnf,
	// Software control.
	input wire logic software_gate,
	input wire logic loadStrobe,
	input wire logic status_clear_request,
	// Status.
	output event_counter_pkg::count_t countValue,
	output event_counter_pkg::count_t latchValue,
	output logic overflow_flag,
	output logic underflow_flag,
	output logic gateOpenOut,
	output logic cmpOut,
	output logic hwIrq,
	output logic [`IRQ_W-1:0] irqCause
);
	import event_counter_pkg::*;

	// The filter counters are 16 bits wide; a clock this fast cannot serve 1 kHz.
	if (FILT_CLK_HZ / `FILT_HZ_PER_KHZ_X2 > `FILT_CNT_MAX) begin : g_chk
		$error("FILT_CLK_HZ too high for 16-bit filter counters");
	end

	// Cycles a pin must hold a new level before it is accepted.
	function automatic logic [15:0] filtCycles(input logic [2:0] sel);
		int unsigned khz;
		int unsigned cyc;
		case (sel)
			`FSEL_1K: khz = `KHZ_1;
			`FSEL_2K: khz = `KHZ_2;
			`FSEL_5K: khz = `KHZ_5;
			`FSEL_10K: khz = `KHZ_10;
			`FSEL_30K: khz = `KHZ_30;
			default: khz = `KHZ_60;
		endcase
		cyc = FILT_CLK_HZ / (`FILT_HZ_PER_KHZ_X2 * khz);
		if (cyc == 0) begin
			cyc = 1;
		end
		filtCycles = cyc[15:0];
	endfunction : filtCycles

	logic [`PIN_N-1:0] rawIn;
	logic [`PIN_N-1:0] syncA_q;
	logic [`PIN_N-1:0] syncB_q;
	logic [`PIN_N-1:0] filt;
	logic [`PIN_N-1:0] filtPrev_q;
	logic [15:0] countLim;
	logic [15:0] latchLim;

	assign rawIn = {latchPin, hardwareGatePin, trackBPin, trackAPin};
	assign countLim = filtCycles(countFreqSel);
	assign latchLim = filtCycles(latchFreqSel);

	// Two-stage synchroniser; only the second stage feeds the filters.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			syncA_q <= '0;
			syncB_q <= '0;
		end else if (clkEn) begin
			syncA_q <= rawIn;
			syncB_q <= syncA_q;
		end
	end

	// Glitch filter per pin: a level is taken only after it held for the selected time.
	for (genvar i = 0; i < `PIN_N; i++) begin : g_filt
		logic [15:0] cnt_q;
		logic lvl_q;
		logic [15:0] lim;
		assign lim = (i == `PIN_LATCH) ? latchLim : countLim;
		assign filt[i] = lvl_q;
		always_ff @(posedge sys_clk) begin
			if (!rstn) begin
				cnt_q <= 16'h0000;
				lvl_q <= 1'b0;
			end else if (clkEn) begin
				if (syncB_q[i] == lvl_q) begin
					cnt_q <= 16'h0000;
				end else if (cnt_q >= lim - 16'h0001) begin
					lvl_q <= syncB_q[i];
					cnt_q <= 16'h0000;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end

	// Previous filtered levels for edge detection.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			filtPrev_q <= '0;
		end else if (clkEn) begin
			filtPrev_q <= filt;
		end
	end

	logic trkA;
	logic trkB;
	logic aRise;
	logic aChg;
	logic bChg;
	logic hwRise;
	logic hwFall;
	logic latchRise;
	assign trkA = filt[`PIN_A];
	assign trkB = filt[`PIN_B];
	assign aRise = trkA & ~filtPrev_q[`PIN_A];
	assign aChg = trkA ^ filtPrev_q[`PIN_A];
	assign bChg = trkB ^ filtPrev_q[`PIN_B];
	assign hwRise = filt[`PIN_GATE] & ~filtPrev_q[`PIN_GATE];
	assign hwFall = ~filt[`PIN_GATE] & filtPrev_q[`PIN_GATE];
	assign latchRise = filt[`PIN_LATCH] & ~filtPrev_q[`PIN_LATCH];

	// Step decode; in quadrature, track A leading track B means forward.
	logic stepValid;
	logic stepUp;
	always_comb begin
		stepValid = 1'b0;
		stepUp = 1'b0;
		case (signalEval)
			EVAL_PULSE_DIR: begin
				stepValid = aRise;
				stepUp = ~trkB;
			end
			EVAL_X1: begin
				stepValid = aRise;
				stepUp = ~trkB;
			end
			EVAL_X2: begin
				stepValid = aChg;
				stepUp = trkA ^ trkB;
			end
			EVAL_X4: begin
				stepValid = aChg | bChg;
				stepUp = trkA ^ filtPrev_q[`PIN_B];
			end
			default: begin
				stepValid = 1'b0;
				stepUp = 1'b0;
			end
		endcase
		stepUp = stepUp ^ dirInvert;
	end

	// Gate: software alone, or software and hardware gate together.
	logic gateTerm;
	logic gateTermPrev_q;
	logic gateRise;
	logic autoClosed_q;
	logic gateOpen;
	logic closeEvt;
	assign gateTerm = software_gate & (hwGateEnable ? filt[`PIN_GATE] : 1'b1);
	assign gateRise = gateTerm & ~gateTermPrev_q;
	assign gateOpen = gateTerm & ~autoClosed_q;

	// An automatic close holds until the gate term rises again.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			gateTermPrev_q <= 1'b0;
			autoClosed_q <= 1'b0;
		end else if (clkEn) begin
			gateTermPrev_q <= gateTerm;
			if (closeEvt) begin
				autoClosed_q <= 1'b1;
			end else if (gateRise) begin
				autoClosed_q <= 1'b0;
			end
		end
	end

	// Next count and limit events for one counting pulse.
	count_t count_q;
	count_t nextCnt;
	logic ovfEvt;
	logic unfEvt;
	logic useEnd;
	logic stepNow;
	assign stepNow = stepValid & gateOpen;
	assign useEnd = (opMode != MODE_CONT);
	always_comb begin
		nextCnt = stepUp ? count_q + `CNT_ONE : count_q - `CNT_ONE;
		ovfEvt = 1'b0;
		unfEvt = 1'b0;
		if (stepUp && useEnd && mainDir == DIR_FWD && count_q == endValue - `CNT_ONE) begin
			nextCnt = loadValue;
			ovfEvt = 1'b1;
		end else if (!stepUp && useEnd && mainDir == DIR_BWD && count_q == endValue + `CNT_ONE) begin
			nextCnt = loadValue;
			unfEvt = 1'b1;
		end else if (stepUp && count_q == `CNT_UPPER_LIMIT) begin
			ovfEvt = 1'b1;
			if (opMode == MODE_PERIODIC && mainDir == DIR_NONE) begin
				nextCnt = loadValue;
			end else begin
				nextCnt = `CNT_LOWER_LIMIT;
			end
		end else if (!stepUp && count_q == `CNT_LOWER_LIMIT) begin
			unfEvt = 1'b1;
			if (opMode == MODE_PERIODIC && mainDir == DIR_NONE) begin
				nextCnt = loadValue;
			end else begin
				nextCnt = `CNT_UPPER_LIMIT;
			end
		end
	end
	assign closeEvt = stepNow & (opMode == MODE_ONCE) & (ovfEvt | unfEvt);

	// Count register: software load, abort-type reopen, then counting pulses.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			count_q <= `CNT_RESET;
		end else if (clkEn) begin
			if (loadStrobe) begin
				count_q <= loadValue;
			end else if (gateRise && gateAbort) begin
				count_q <= loadValue;
			end else if (stepNow) begin
				count_q <= nextCnt;
			end
		end
	end

	// Sticky flags; an event in the clearing cycle wins over the clear.
	logic ovfHit;
	logic unfHit;
	logic ovfFlag_q;
	logic unfFlag_q;
	assign ovfHit = stepNow & ovfEvt;
	assign unfHit = stepNow & unfEvt;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ovfFlag_q <= 1'b0;
			unfFlag_q <= 1'b0;
		end else if (clkEn) begin
			ovfFlag_q <= ovfHit | (ovfFlag_q & ~status_clear_request);
			unfFlag_q <= unfHit | (unfFlag_q & ~status_clear_request);
		end
	end

	// Comparator; a trigger is the rise of the selected condition.
	logic cmpCond;
	logic cmpCond_q;
	logic cmpTrig;
	always_comb begin
		case (cmpMode)
			CMP_GE: cmpCond = (count_q >= cmpValue);
			CMP_LE: cmpCond = (count_q <= cmpValue);
			CMP_EQ: cmpCond = (count_q == cmpValue);
			default: cmpCond = 1'b0;
		endcase
	end
	assign cmpTrig = cmpCond & ~cmpCond_q;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cmpCond_q <= 1'b0;
		end else if (clkEn) begin
			cmpCond_q <= cmpCond;
		end
	end

	// Interrupt events, registered into a one-cycle pulse with its causes.
	logic [`IRQ_W-1:0] causes;
	logic [`IRQ_W-1:0] cause_q;
	logic irq_q;
	always_comb begin
		causes = '0;
		causes[`IRQ_GATE_OPEN] = irqEnGateOpen & hwRise & software_gate;
		causes[`IRQ_GATE_CLOSE] = irqEnGateClose & hwFall & software_gate;
		causes[`IRQ_CMP] = irqEnCmp & cmpTrig;
		causes[`IRQ_OVF] = irqEnOvf & ovfHit;
		causes[`IRQ_UNF] = irqEnUnf & unfHit;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irq_q <= 1'b0;
			cause_q <= '0;
		end else if (clkEn) begin
			irq_q <= |causes;
			if (|causes) begin
				cause_q <= causes;
			end
		end
	end

	// Latch captures the count on a latch rising edge while counting is enabled.
	count_t latch_q;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			latch_q <= `CNT_RESET;
		end else if (clkEn && latchRise && gateOpen) begin
			latch_q <= count_q;
		end
	end

	// Registered gate and comparator status.
	logic gateOpen_q;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			gateOpen_q <= 1'b0;
		end else if (clkEn) begin
			gateOpen_q <= gateOpen;
		end
	end

	assign countValue = count_q;
	assign latchValue = latch_q;
	assign overflow_flag = ovfFlag_q;
	assign underflow_flag = unfFlag_q;
	assign gateOpenOut = gateOpen_q;
	assign cmpOut = cmpCond_q;
	assign hwIrq = irq_q;
	assign irqCause = cause_q;
endmodule : multi_mode_event_counter
`default_nettype wire

// File: verif/multi_mode_event_counter_chk.sv
// Port assertions for the multi-mode event counter.
`default_nettype none
module multi_mode_event_counter_chk (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rstn,
	// Inputs watched.
	input wire event_counter_pkg::op_mode_t opMode,
	input wire logic irqEnOvf,
	input wire logic irqEnUnf,
	input wire logic software_gate,
	input wire logic loadStrobe,
	input wire logic status_clear_request,
	// Outputs watched.
	input wire event_counter_pkg::count_t countValue,
	input wire logic overflow_flag,
	input wire logic underflow_flag,
	input wire logic gateOpenOut,
	input wire logic hwIrq
);
	timeunit 1ns;
	timeprecision 1ns;
	import event_counter_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Gate shut and no load for three samples, which outlasts the internal gate delay.
	sequence s_idle;
		(!software_gate && !loadStrobe) [*3];
	endsequence
	a_irq_pulse: assert property (hwIrq |=> !hwIrq) else $error("irq pulse too long");
	a_ovf_hold: assert property (overflow_flag && !status_clear_request |=> overflow_flag)
		else $error("overflow flag dropped");
	a_unf_hold: assert property (underflow_flag && !status_clear_request |=> underflow_flag)
		else $error("underflow flag dropped");
	// Flag and interrupt pulse leave the same clock edge, so the pulse stands while the flag rises.
	a_ovf_irq: assert property ($rose(overflow_flag) && irqEnOvf |-> hwIrq) else $error("no overflow irq");
	a_unf_irq: assert property ($rose(underflow_flag) && irqEnUnf |-> hwIrq) else $error("no underflow irq");
	a_top_wrap: assert property (opMode == MODE_CONT && !$past(loadStrobe) &&
		$past(countValue) == 32'sh7FFFFFFF && countValue == 32'sh80000000 |-> overflow_flag)
		else $error("top wrap without flag");
	a_bottom_wrap: assert property (opMode == MODE_CONT && !$past(loadStrobe) &&
		$past(countValue) == 32'sh80000000 && countValue == 32'sh7FFFFFFF |-> underflow_flag)
		else $error("bottom wrap without flag");
	a_idle_hold: assert property (s_idle |-> $stable(countValue)) else $error("count moved, gate shut");
	a_gate_sw: assert property (gateOpenOut |-> $past(software_gate)) else $error("gate open, sw low");
endmodule : multi_mode_event_counter_chk
bind multi_mode_event_counter multi_mode_event_counter_chk i_chk (.*);
`default_nettype wire

// File: verif/pulse_source_model.sv
// Pulse and direction source model standing in for the encoder side.
`default_nettype none
module pulse_source_model (
	// Clock.
	input wire logic sys_clk,
	// Pins toward the counter.
	output logic trackAPin,
	output logic trackBPin,
	output logic hardwareGatePin,
	output logic latchPin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins rest low; the latch pin stays idle, the gate pin moves only in gateLevel.
	initial begin
		trackAPin = 1'h0;
		trackBPin = 1'h0;
		hardwareGatePin = 1'h0;
		latchPin = 1'h0;
	end
	// One count pulse; direction is set well ahead since both pins pass the same filter delay.
	task automatic step(input logic fwd);
		trackBPin <= ~fwd;
		repeat (40) @(posedge sys_clk);
		trackAPin <= 1'h1;
		repeat (40) @(posedge sys_clk);
		trackAPin <= 1'h0;
		repeat (40) @(posedge sys_clk);
	endtask : step
	// Move the hardware gate pin and wait well past the filter delay.
	task automatic gateLevel(input logic lvl);
		hardwareGatePin <= lvl;
		repeat (40) @(posedge sys_clk);
	endtask : gateLevel
endmodule : pulse_source_model
`default_nettype wire

// File: verif/multi_mode_event_counter_tb.sv
// Self-checking bench for the multi-mode event counter.
`default_nettype none
module multi_mode_event_counter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import event_counter_pkg::*;
	logic sys_clk, rstn, trackAPin, trackBPin, hardwareGatePin, latchPin;
	logic software_gate, loadStrobe, status_clear_request, dirInvert, hwGateEnable, gateAbort;
	logic clkEn, irqEnGateOpen, irqEnGateClose, irqEnCmp, irqEnOvf, irqEnUnf, clrCause;
	count_t cmpValue;
	logic overflow_flag, underflow_flag, gateOpenOut, cmpOut, hwIrq;
	logic [4:0] irqCause, causeSeen;
	op_mode_t opMode;
	main_dir_t mainDir;
	count_t loadValue, endValue, countValue;
	int numErrors = 0;
	int samplesChecked = 0;
	// Slow filter time base keeps a 60 kHz filter at 16 cycles.
	multi_mode_event_counter #(.FILT_CLK_HZ(2000000)) i_dut (.*, .signalEval(EVAL_PULSE_DIR),
		.cmpMode(CMP_NONE), .countFreqSel(3'h5), .latchFreqSel(3'h3), .latchValue());
	pulse_source_model i_src (.*);
	// Clock.
	initial begin
		sys_clk = 1'h0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Gather interrupt causes, since the pulse is gone before a scenario looks.
	always @(posedge sys_clk) begin
		if (!rstn || clrCause) begin
			causeSeen <= 5'h00;
		end else if (hwIrq === 1'h1) begin
			causeSeen <= causeSeen | irqCause;
		end
	end
	task automatic chk(input count_t got, input count_t exp);
		samplesChecked++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb
	task automatic load(input count_t v);
		loadValue <= v;
		loadStrobe <= 1'h1;
		@(posedge sys_clk);
		loadStrobe <= 1'h0;
		@(posedge sys_clk);
	endtask : load
	task automatic closeOut;
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : closeOut
	// Cut a hung run short.
	initial begin
		repeat (20000) @(posedge sys_clk);
		numErrors++;
		closeOut;
	end
	// Main sequence: wraps, sticky flags, count once forward, periodic backward.
	initial begin
		rstn = 1'h0;
		software_gate = 1'h0;
		loadStrobe = 1'h0;
		status_clear_request = 1'h0;
		dirInvert = 1'h0;
		hwGateEnable = 1'h0;
		gateAbort = 1'h0;
		clkEn = 1'h1;
		cmpValue = 32'sh0;
		clrCause = 1'h0;
		irqEnGateOpen = 1'h1;
		irqEnGateClose = 1'h1;
		irqEnCmp = 1'h1;
		irqEnOvf = 1'h1;
		irqEnUnf = 1'h1;
		opMode = MODE_CONT;
		mainDir = DIR_NONE;
		loadValue = 32'sh0;
		endValue = 32'sh0;
		repeat (10) @(posedge sys_clk);
		rstn <= 1'h1;
		@(posedge sys_clk);
		chk(countValue, 32'sh0);
		load(32'sh7FFFFFFE);
		software_gate <= 1'h1;
		i_src.step(1'h1);
		i_src.step(1'h1);
		chk(countValue, 32'sh80000000);
		chkb(overflow_flag & causeSeen[3], 1'h1);
		i_src.step(1'h0);
		chk(countValue, 32'sh7FFFFFFF);
		chkb(underflow_flag & overflow_flag & causeSeen[4], 1'h1);
		status_clear_request <= 1'h1;
		@(posedge sys_clk);
		status_clear_request <= 1'h0;
		@(posedge sys_clk);
		chkb(overflow_flag | underflow_flag, 1'h0);
		software_gate <= 1'h0;
		opMode <= MODE_ONCE;
		mainDir <= DIR_FWD;
		endValue <= 32'sh3;
		load(32'sh1);
		software_gate <= 1'h1;
		i_src.step(1'h1);
		i_src.step(1'h1);
		chk(countValue, 32'sh1);
		chkb(gateOpenOut, 1'h0);
		i_src.step(1'h1);
		chk(countValue, 32'sh1);
		software_gate <= 1'h0;
		repeat (2) @(posedge sys_clk);
		software_gate <= 1'h1;
		repeat (3) @(posedge sys_clk);
		chkb(gateOpenOut, 1'h1);
		i_src.step(1'h1);
		chk(countValue, 32'sh2);
		software_gate <= 1'h0;
		opMode <= MODE_PERIODIC;
		mainDir <= DIR_BWD;
		clrCause <= 1'h1;
		load(32'sh5);
		clrCause <= 1'h0;
		software_gate <= 1'h1;
		i_src.step(1'h0);
		chk(countValue, 32'sh4);
		i_src.step(1'h0);
		chk(countValue, 32'sh5);
		chkb(gateOpenOut & underflow_flag & causeSeen[4], 1'h1);
		// A pulse while the clock enable is low must leave no trace.
		clkEn <= 1'h0;
		i_src.step(1'h0);
		clkEn <= 1'h1;
		repeat (3) @(posedge sys_clk);
		chk(countValue, 32'sh5);
		// Abort-type reopen reloads the load value.
		i_src.step(1'h0);
		chk(countValue, 32'sh4);
		gateAbort <= 1'h1;
		software_gate <= 1'h0;
		repeat (2) @(posedge sys_clk);
		software_gate <= 1'h1;
		repeat (3) @(posedge sys_clk);
		chk(countValue, 32'sh5);
		// Hardware gate edges raise their interrupts; once enabled the gate pin closes counting.
		clrCause <= 1'h1;
		@(posedge sys_clk);
		clrCause <= 1'h0;
		i_src.gateLevel(1'h1);
		chkb(causeSeen[0], 1'h1);
		hwGateEnable <= 1'h1;
		i_src.gateLevel(1'h0);
		chkb(gateOpenOut, 1'h0);
		chkb(causeSeen[1], 1'h1);
		closeOut;
	end
endmodule : multi_mode_event_counter_tb
`default_nettype wire
